// *** hdl/dmr_dma_request.sv ***
module dmr_dma_request
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`DMR_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Transfer requests and acknowledges
   input wire logic [`DMR_NCH-1:0] interrupt_control_unit_transfer_request_n_i,
   input wire logic [`DMR_NCH-1:0] pin_transfer_request_n_i,
   input wire logic [1:0] pin_b_transfer_request_n_i,
   output logic [`DMR_NCH-1:0] transfer_acknowledge_n_o,
   // Transfer bus master
   input wire logic [1:0] mem_bus_width_i,
   input wire logic bus_gnt_i,
   output logic bus_req_o,
   output dmr_pkg::dmr_mem_req_type mem_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i
);
   import dmr_pkg::*;

   dmr_state_type q;
   dmr_state_type d;

   // Log2 of byte count for a size code
   // Code 0x means 32 bits, so bit 0 does not matter there
   function automatic logic [1:0] size_lg(input logic [1:0] c);
      size_lg = c[1] ? (c[0] ? 2'd0 : 2'd1) : 2'd2;
   endfunction

   // Byte-enable merge for register writes
   // Lanes without a byte enable keep their old value
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
            r[b*8 +: 8] = n[b*8 +: 8];
      end
      merge = r;
   endfunction

   // Configuration check run when go is written
   // Set done flags count as errors, so software must clear them before a restart
   function automatic logic cfg_bad(input logic [15:0] c, input logic [31:0] n,
                                    input logic [31:0] s, input logic [31:0] t,
                                    input logic done_flag, input logic ab_flag);
      logic [1:0] ulg;
      logic [1:0] plg;
      logic sio;
      logic dio;
      logic io;
      logic [31:0] amask;
      ulg = size_lg(c[`DMR_C_UNIT +: 2]);
      plg = size_lg(c[`DMR_C_PORT +: 2]);
      sio = c[`DMR_C_SRC_IO];
      dio = c[`DMR_C_DST_IO];
      io = sio | dio;
      amask = (32'h1 << ulg) - 32'h1;
      cfg_bad = (sio & dio) | done_flag | ab_flag | (n == 32'h0)
         | (((n | s | t) & amask) != 32'h0)
         | (io & (plg > ulg))
         | (~c[`DMR_C_EXT] & io)
         | (c[`DMR_C_EXT] & c[`DMR_C_USE_PIN] & c[`DMR_C_POL])
         | (c[`DMR_C_EXT] & c[`DMR_C_USE_PIN] & ~io & ~c[`DMR_C_LEVEL])
         | (c[`DMR_C_EXT] & c[`DMR_C_USE_PIN] & sio & c[`DMR_C_LEVEL]);
   endfunction

   // Lane mask for an access of 2^lg bytes
   function automatic logic [31:0] lane_mask(input logic [1:0] lg);
      lane_mask = (lg == 2'd2) ? 32'hFFFFFFFF : ((lg == 2'd1) ? 32'h0000FFFF : 32'h000000FF);
   endfunction

   logic [`DMR_NCH-1:0] raw_pin;
   logic [`DMR_NCH-1:0] chan_req;
   logic any_req;
   logic [2:0] win_ch;
   logic [15:0] cc;
   logic cur_sio;
   logic cur_dio;
   logic ph_io;
   logic [1:0] ulg;
   logic [1:0] wlg;
   logic [1:0] last_acc;
   logic [4:0] shamt;
   logic [31:0] base;
   logic [31:0] ubytes;
   logic [31:0] new_cnt;
   logic [2:0] wch;
   logic [2:0] widx;
   logic [31:0] ctrl_wr;

   // Pin routing; first port has precedence for channels 2 and 3
   // Unrouted channels 2 and 3 see an idle high level, never a request
   always_comb
   begin
      raw_pin = pin_transfer_request_n_i;
      raw_pin[2] = q.port_a[`DMR_PF_CH2] ? pin_transfer_request_n_i[2] :
                   (q.port_b[`DMR_PF_CH2] ? pin_b_transfer_request_n_i[0] : 1'b1);
      raw_pin[3] = q.port_a[`DMR_PF_CH3] ? pin_transfer_request_n_i[3] :
                   (q.port_b[`DMR_PF_CH3] ? pin_b_transfer_request_n_i[1] : 1'b1);
   end

   // Per-channel request sources and fixed priority, lowest index first
   // Level mode follows the filtered pin, so a released pin drops the request only after the synchroniser delay
   always_comb
   begin
      chan_req = '0;
      any_req = 1'b0;
      win_ch = 3'h0;
      for (int n = 0; n < `DMR_NCH; n++)
      begin
         if (!q.ctrl[n][`DMR_C_EXT])
            chan_req[n] = q.act[n];
         else if (!q.ctrl[n][`DMR_C_USE_PIN])
            chan_req[n] = q.act[n] & ~interrupt_control_unit_transfer_request_n_i[n];
         else if (q.ctrl[n][`DMR_C_LEVEL])
            chan_req[n] = q.act[n] & ~q.filt[n];
         else
            chan_req[n] = q.act[n] & q.edge_pend[n];
      end
      for (int n = `DMR_NCH - 1; n >= 0; n--)
      begin
         if (chan_req[n])
         begin
            any_req = 1'b1;
            win_ch = 3'(n);
         end
      end
   end

   // Geometry of the current unit and access
   always_comb
   begin
      cc = q.ctrl[q.cur_ch];
      cur_sio = cc[`DMR_C_SRC_IO];
      cur_dio = cc[`DMR_C_DST_IO];
      ph_io = (q.eng == DMR_READ) ? cur_sio : cur_dio;
      ulg = size_lg(cc[`DMR_C_UNIT +: 2]);
      // Port width applies on the IO phase only; memory splits by bus width
      if (ph_io)
         wlg = size_lg(cc[`DMR_C_PORT +: 2]);
      else if (size_lg(mem_bus_width_i) < ulg)
         wlg = size_lg(mem_bus_width_i);
      else
         wlg = ulg;
      last_acc = 2'((3'h1 << (ulg - wlg)) - 3'h1);
      shamt = 5'({3'h0, q.acc} << (3'd3 + {1'b0, wlg}));
      base = (q.eng == DMR_READ) ? q.src[q.cur_ch] : q.dst[q.cur_ch];
      ubytes = 32'h1 << ulg;
      new_cnt = q.cnt[q.cur_ch] - ubytes;
      wch = wb_adr_i[7:5];
      widx = wb_adr_i[4:2];
      // Control write image, trimmed to the bits that hold state
      ctrl_wr = merge({16'h0, q.ctrl[wch]}, wb_dat_i, wb_sel_i) & {16'h0, `DMR_CTRL_KEEP};
   end

   // Next state: register bus, engine, then pin detection
   always_comb
   begin
      d = q;
      // Register bus; one wait state, then a single-cycle ack
      // Go reads back as the active flag so software can poll one bit
      d.wb_ack = wb_cyc_i & wb_stb_i & ~q.wb_ack;
      d.wb_dat = 32'h0;
      if (d.wb_ack)
      begin
         if (wb_adr_i == `DMR_ADR_PORTA)
         begin
            d.wb_dat = {30'h0, q.port_a};
            if (wb_we_i && wb_sel_i[0])
               d.port_a = wb_dat_i[1:0];
         end
         else if (wb_adr_i == `DMR_ADR_PORTB)
         begin
            d.wb_dat = {30'h0, q.port_b};
            if (wb_we_i && wb_sel_i[0])
               d.port_b = wb_dat_i[1:0];
         end
         else if (!wb_adr_i[8])
         begin
            case (widx)
               `DMR_IDX_CTRL: d.wb_dat = {16'h0, q.ctrl[wch] | {15'h0, q.act[wch]}};
               `DMR_IDX_SRC: d.wb_dat = q.src[wch];
               `DMR_IDX_DST: d.wb_dat = q.dst[wch];
               `DMR_IDX_CNT: d.wb_dat = q.cnt[wch];
               `DMR_IDX_STAT: d.wb_dat = {28'h0, q.conf[wch], q.abn[wch], q.nc[wch], q.act[wch]};
               default: d.wb_dat = 32'h0;
            endcase
            // Setup registers are frozen while the channel runs
            if (wb_we_i && !q.act[wch])
            begin
               case (widx)
                  `DMR_IDX_CTRL:
                  begin
                     d.ctrl[wch] = ctrl_wr[15:0];
                     if (wb_sel_i[0] && wb_dat_i[`DMR_C_GO])
                     begin
                        if (cfg_bad(d.ctrl[wch], q.cnt[wch], q.src[wch], q.dst[wch],
                                    q.nc[wch], q.abn[wch]))
                        begin
                           d.abn[wch] = 1'b1;
                           d.conf[wch] = 1'b1;
                        end
                        else
                           d.act[wch] = 1'b1;
                     end
                  end
                  `DMR_IDX_SRC: d.src[wch] = merge(q.src[wch], wb_dat_i, wb_sel_i);
                  `DMR_IDX_DST: d.dst[wch] = merge(q.dst[wch], wb_dat_i, wb_sel_i);
                  `DMR_IDX_CNT: d.cnt[wch] = merge(q.cnt[wch], wb_dat_i, wb_sel_i);
                  default: d.cnt[wch] = d.cnt[wch];
               endcase
            end
            // Status flags clear by writing ones; engine sets below win
            if (wb_we_i && widx == `DMR_IDX_STAT && wb_sel_i[0])
            begin
               d.nc[wch] = q.nc[wch] & ~wb_dat_i[`DMR_S_NC];
               d.abn[wch] = q.abn[wch] & ~wb_dat_i[`DMR_S_ABN];
               d.conf[wch] = q.conf[wch] & ~wb_dat_i[`DMR_S_CONF];
            end
         end
      end

      // Transfer engine
      // Only one unit is in flight; a unit is never split across channels
      case (q.eng)
         DMR_IDLE:
         begin
            // Priority is re-decided only between whole units
            if (any_req)
            begin
               d.cur_ch = win_ch;
               d.acc = 2'h0;
               d.edge_pend[win_ch] = 1'b0;
               d.eng = DMR_READ;
            end
         end
         DMR_READ, DMR_WRITE:
         begin
            if (!q.mreq.req)
            begin
               // A higher master holding the bus just delays the next access
               if (bus_gnt_i)
               begin
                  d.mreq.req = 1'b1;
                  d.mreq.we = (q.eng == DMR_WRITE);
                  d.mreq.io = ph_io;
                  d.mreq.size = (wlg == 2'd2) ? 2'h0 : ((wlg == 2'd1) ? `DMR_SZ_16 : `DMR_SZ_8);
                  d.mreq.addr = ph_io ? base : base + ({30'h0, q.acc} << wlg);
                  d.mreq.wdata = (q.hold >> shamt) & lane_mask(wlg);
               end
            end
            // Read lanes fill the holding register in the order they go back out
            else if (mem_ack_i)
            begin
               d.mreq.req = 1'b0;
               if (q.eng == DMR_READ)
                  d.hold = (q.hold & ~(lane_mask(wlg) << shamt))
                           | ((mem_rdata_i & lane_mask(wlg)) << shamt);
               if (q.acc == last_acc)
               begin
                  d.acc = 2'h0;
                  d.eng = (q.eng == DMR_READ) ? DMR_WRITE : DMR_STEP;
               end
               else
                  d.acc = q.acc + 2'h1;
            end
         end
         DMR_STEP:
         begin
            // IO side keeps a fixed address
            // A spent count ends the channel; external mem-to-mem acks below
            d.cnt[q.cur_ch] = new_cnt;
            if (!cur_sio)
               d.src[q.cur_ch] = q.src[q.cur_ch] + ubytes;
            if (!cur_dio)
               d.dst[q.cur_ch] = q.dst[q.cur_ch] + ubytes;
            if (new_cnt == 32'h0)
            begin
               d.act[q.cur_ch] = 1'b0;
               d.nc[q.cur_ch] = 1'b1;
            end
            d.eng = DMR_IDLE;
         end
         default: d.eng = DMR_IDLE;
      endcase

      // Acknowledge: each IO cycle, or once when an external memory-to-memory count is spent
      // An interrupt_control_unit request withdrawn after selection may still get this unit;
      // the requester must tolerate one extra transfer
      d.ack_n = '1;
      if (d.mreq.req && d.mreq.io && cc[`DMR_C_EXT])
         d.ack_n[q.cur_ch] = 1'b0;
      if (q.eng == DMR_STEP && new_cnt == 32'h0 && cc[`DMR_C_EXT] && !cur_sio && !cur_dio)
         d.ack_n[q.cur_ch] = 1'b0;

      // Pin synchronisers; a change counts when stages two and three agree
      d.sync1 = raw_pin;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      // A stopped channel drops a latched edge so a restart waits for a fresh one
      for (int n = 0; n < `DMR_NCH; n++)
      begin
         if (q.sync2[n] == q.sync3[n])
            d.filt[n] = q.sync3[n];
         if (q.filt[n] && !d.filt[n] && q.act[n])
            d.edge_pend[n] = 1'b1;
         else if (!q.act[n])
            d.edge_pend[n] = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.eng <= DMR_IDLE;
         q.ack_n <= '1;
         // Filter starts high like an idle pin, so no false edge follows reset
         q.sync1 <= '1;
         q.sync2 <= '1;
         q.sync3 <= '1;
         q.filt <= '1;
      end
      else
         q <= d;
   end

   // Outputs
   // Bus request decodes the state register, so it cannot glitch mid-unit
   assign wb_ack_o = q.wb_ack;
   assign wb_dat_o = q.wb_dat;
   assign transfer_acknowledge_n_o = q.ack_n;
   assign mem_o = q.mreq;
   assign bus_req_o = (q.eng == DMR_READ) || (q.eng == DMR_WRITE);

endmodule

// *** hdl/dmr_map.svh ***
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH

// Channel count and register bus address width
`define DMR_NCH 8
`define DMR_ADR_W 9

// Register index inside a channel window (byte address = ch*0x20 + idx*4)
`define DMR_IDX_CTRL 3'h0
`define DMR_IDX_SRC 3'h1
`define DMR_IDX_DST 3'h2
`define DMR_IDX_CNT 3'h3
`define DMR_IDX_STAT 3'h4

// Global registers (byte addresses)
`define DMR_ADR_PORTA 9'h100
`define DMR_ADR_PORTB 9'h104

// channel_control_reg fields
`define DMR_C_GO 0
`define DMR_C_EXT 1
`define DMR_C_UNIT 2
`define DMR_C_PORT 4
`define DMR_C_SRC_IO 6
`define DMR_C_DST_IO 7
`define DMR_C_USE_PIN 8
`define DMR_C_LEVEL 12
`define DMR_C_POL 13
`define DMR_CTRL_KEEP 16'h31FE
`define DMR_CTRL_RST 16'h0000

// Channel status fields
`define DMR_S_ACT 0
`define DMR_S_NC 1
`define DMR_S_ABN 2
`define DMR_S_CONF 3

// Port function bits: bit0 routes channel 2, bit1 routes channel 3
`define DMR_PF_CH2 0
`define DMR_PF_CH3 1

// Size codes shared by unit and port fields
`define DMR_SZ_16 2'h2
`define DMR_SZ_8 2'h3

`endif

// *** hdl/dmr_pkg.sv ***
package dmr_pkg;
`include "dmr_map.svh"

   // Transfer engine states
   typedef enum logic [3:0]
   {
      DMR_IDLE  = 4'h1,
      DMR_READ  = 4'h2,
      DMR_WRITE = 4'h4,
      DMR_STEP  = 4'h8
   } dmr_eng_type;

   // One access on the transfer bus
   typedef struct packed
   {
      logic req;
      logic we;
      logic io;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dmr_mem_req_type;

   // Whole state of the block
   typedef struct packed
   {
      dmr_eng_type eng;
      logic [2:0] cur_ch;
      logic [1:0] acc;
      logic [31:0] hold;
      dmr_mem_req_type mreq;
      logic [`DMR_NCH-1:0] ack_n;
      logic [`DMR_NCH-1:0][15:0] ctrl;
      logic [`DMR_NCH-1:0][31:0] src;
      logic [`DMR_NCH-1:0][31:0] dst;
      logic [`DMR_NCH-1:0][31:0] cnt;
      logic [`DMR_NCH-1:0] act;
      logic [`DMR_NCH-1:0] nc;
      logic [`DMR_NCH-1:0] abn;
      logic [`DMR_NCH-1:0] conf;
      logic [`DMR_NCH-1:0] sync1;
      logic [`DMR_NCH-1:0] sync2;
      logic [`DMR_NCH-1:0] sync3;
      logic [`DMR_NCH-1:0] filt;
      logic [`DMR_NCH-1:0] edge_pend;
      logic [1:0] port_a;
      logic [1:0] port_b;
      logic wb_ack;
      logic [31:0] wb_dat;
   } dmr_state_type;

endpackage

// *** verif/dmr_dma_request_bench.sv ***
`include "dmr_map.svh"
module dmr_dma_request_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dmr_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_ack_i, bus_req_o;
   logic [8:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, mem_rdata_i, q;
   logic [7:0] interrupt_control_unit_n, pin_n, ack_n, raise;
   logic [3:0] lat;
   logic [1:0] width;
   logic [1:0] pin_b_n;
   dmr_mem_req_type mem_o;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [15:0] bad [4] = '{16'h004A, 16'h0080, 16'h3102, 16'h0102};
   dmr_dma_request dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .interrupt_control_unit_transfer_request_n_i(interrupt_control_unit_n), .pin_transfer_request_n_i(pin_n),
      .pin_b_transfer_request_n_i(pin_b_n), .transfer_acknowledge_n_o(ack_n),
      .mem_bus_width_i(width), .bus_gnt_i(1'b1), .bus_req_o(bus_req_o), .mem_o(mem_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
   dmr_far_end u_far (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o), .lat_i(lat),
      .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .raise_i(raise), .ack_n_i(ack_n),
      .interrupt_control_unit_n_o(interrupt_control_unit_n));
   task automatic wrap_up();
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic cycle; ack and data taken at the same edge
   task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n == 50)
         chk({31'h0, wb_ack_o}, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // Poll a register until it shows the expected value; always reads once
   task automatic poll(input logic [8:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      for (int i = 0; i < 100 && q !== exp; i++)
         wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   function automatic logic [8:0] ra(input int ch, input int idx);
      return 9'(ch * 32 + idx * 4);
   endfunction
   function automatic logic [31:0] pv(input logic [31:0] a);
      return {24'h0, a[7:0] ^ 8'h5A};
   endfunction
   task automatic start(input int ch, input logic [31:0] s, d, n, input logic [15:0] c);
      wb(1'b1, ra(ch, 1), s);
      wb(1'b1, ra(ch, 2), d);
      wb(1'b1, ra(ch, 3), n);
      wb(1'b1, ra(ch, 0), {16'h0, c | 16'h1});
      q = 32'hFFFF_FFFF;
   endtask
   task automatic pulse_interrupt_control_unit(input logic [7:0] m);
      @(posedge clk_i);
      raise <= m;
      @(posedge clk_i);
      raise <= 8'h0;
   endtask
   // Clock and hang guard
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         wrap_up();
      end
   end
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 44'h0};
      pin_n = 8'hFF;
      pin_b_n = 2'h3;
      raise = 8'h0;
      lat = 4'h3;
      width = `DMR_SZ_16;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(ra(0, 0), 32'h0);
      rchk(ra(0, 4), 32'h0);
      wb(1'b1, 9'h1F0, 32'hFFFF_FFFF);
      rchk(9'h1F0, 32'h0);
      // Internal mem to mem, 32-bit units over a 16-bit bus
      start(1, 32'h1000, 32'h2000, 32'h8, 16'h0000);
      poll(ra(1, 4), 32'h2);
      chk(32'(u_far.acc_n), 32'h8);
      rchk(ra(1, 1), 32'h1008);
      rchk(ra(1, 2), 32'h2008);
      for (int i = 0; i < 8; i++)
         chk({24'h0, u_far.mem[32'h2000 + i]}, pv(32'h1000 + i));
      // Prohibited setups on channel 3, each refused at start
      foreach (bad[i])
      begin
         wb(1'b1, ra(3, 4), 32'hE);
         start(3, 32'h100, 32'h200, 32'h4, bad[i]);
         poll(ra(3, 4), 32'hC);
      end
      chk(32'(u_far.acc_n), 32'h8);
      // Interrupt_control_unit mem to io, 16-bit unit on 8-bit port, one unit per request
      lat <= 4'h0;
      width <= 2'h0;
      start(4, 32'h3000, 32'h40, 32'h4, 16'h00BA);
      repeat (20) @(posedge clk_i);
      chk(32'(u_far.acc_n), 32'h8);
      pulse_interrupt_control_unit(8'h10);
      poll(ra(4, 3), 32'h2);
      repeat (20) @(posedge clk_i);
      rchk(ra(4, 3), 32'h2);
      chk(32'(u_far.acc_n), 32'hB);
      pulse_interrupt_control_unit(8'h10);
      poll(ra(4, 4), 32'h2);
      for (int i = 0; i < 4; i++)
         chk({24'h0, u_far.iow[i]}, pv(32'h3000 + i));
      // Pin edge io to mem: a held low pin gives one unit only
      start(6, 32'h60, 32'h5000, 32'h2, 16'h017E);
      @(posedge clk_i);
      pin_n[6] <= 1'b0;
      repeat (40) @(posedge clk_i);
      rchk(ra(6, 3), 32'h1);
      pin_n[6] <= 1'b1;
      repeat (10) @(posedge clk_i);
      pin_n[6] <= 1'b0;
      poll(ra(6, 4), 32'h2);
      chk({24'h0, u_far.mem[32'h5000]}, 32'h30);
      chk({24'h0, u_far.mem[32'h5001]}, 32'h31);
      // Level pin mem to mem on channel 2 via the second port, 8-bit bus
      width <= `DMR_SZ_8;
      pin_b_n <= 2'h2;
      wb(1'b1, 9'h100, 32'h1);
      wb(1'b1, 9'h104, 32'h1);
      rchk(9'h104, 32'h1);
      start(2, 32'h700, 32'h7100, 32'h4, 16'h110A);
      repeat (20) @(posedge clk_i);
      rchk(ra(2, 3), 32'h4);
      wb(1'b1, 9'h100, 32'h0);
      poll(ra(2, 4), 32'h2);
      pin_b_n <= 2'h3;
      chk(32'(u_far.acc_n), 32'h1A);
      for (int i = 0; i < 4; i++)
         chk({24'h0, u_far.mem[32'h7100 + i]}, pv(32'h700 + i));
      wrap_up();
   end
endmodule
bind dmr_dma_request dmr_dma_request_props u_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .transfer_acknowledge_n_o(transfer_acknowledge_n_o), .mem_bus_width_i(mem_bus_width_i),
   .bus_req_o(bus_req_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i));

// *** verif/dmr_dma_request_props.sv ***
`include "dmr_map.svh"
module dmr_dma_request_props
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Transfer side
   input wire logic [`DMR_NCH-1:0] transfer_acknowledge_n_o,
   input wire logic [1:0] mem_bus_width_i,
   input wire logic bus_req_o,
   input dmr_pkg::dmr_mem_req_type mem_o,
   input wire logic mem_ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // An access still waiting, and one being answered
   sequence s_open;
      mem_o.req && !mem_ack_i;
   endsequence
   sequence s_done;
      mem_o.req && mem_ack_i;
   endsequence
   // Register bus answers in exactly one cycle, then idles
   a_wb_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
      else $error("register access not answered next cycle");
   a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("register ack longer than one cycle");
   a_wb_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   // Transfer bus requests stand until answered
   a_req_hold: assert property (s_open |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata))
      else $error("access changed before its answer");
   a_req_gap: assert property (s_done |=> !mem_o.req)
      else $error("no idle cycle after an access");
   a_bus_owned: assert property (mem_o.req |-> bus_req_o)
      else $error("access without bus request");
   // Narrow memory bus forces byte accesses
   a_narrow_bus: assert property (mem_o.req && !mem_o.io
      && mem_bus_width_i == `DMR_SZ_8 |-> mem_o.size == `DMR_SZ_8)
      else $error("memory access wider than bus");
   // Acknowledge: one channel at a time, low during I/O cycles
   a_ack_single: assert property ($onehot0(~transfer_acknowledge_n_o))
      else $error("acknowledge on several channels");
   a_ack_on_io: assert property (mem_o.req && mem_o.io && $past(mem_o.req)
      |-> transfer_acknowledge_n_o != 8'hFF)
      else $error("no acknowledge during io access");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i
      |=> transfer_acknowledge_n_o == 8'hFF && !mem_o.req && !wb_ack_o)
      else $error("outputs active after reset");
endmodule

// *** verif/dmr_far_end.sv ***
module dmr_far_end
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Memory and io slave
   input dmr_pkg::dmr_mem_req_type mem_i,
   input wire logic [3:0] lat_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o,
   // Interrupt controller requests
   input wire logic [7:0] raise_i,
   input wire logic [7:0] ack_n_i,
   output logic [7:0] interrupt_control_unit_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [31:0]];
   logic [7:0] iow [$];
   int io_rd = 0;
   int acc_n = 0;
   int nb;
   logic [3:0] wait_q;
   // Answer after lat_i waits; idle data toggles so stale lanes never match
   always @(posedge clk_i)
   begin
      mem_rdata_o <= ~mem_rdata_o;
      mem_ack_o <= 1'b0;
      nb = mem_i.size[1] ? (mem_i.size[0] ? 1 : 2) : 4;
      if (rst_i)
      begin
         wait_q <= 4'h0;
         mem_rdata_o <= 32'h0;
      end
      else if (mem_i.req && !mem_ack_o && wait_q < lat_i)
         wait_q <= wait_q + 4'h1;
      else if (mem_i.req && !mem_ack_o)
      begin
         wait_q <= 4'h0;
         mem_ack_o <= 1'b1;
         acc_n++;
         for (int k = 0; k < nb; k++)
         begin
            if (mem_i.we && mem_i.io)
               iow.push_back(mem_i.wdata[k*8 +: 8]);
            else if (mem_i.we)
               mem[mem_i.addr + k] = mem_i.wdata[k*8 +: 8];
            else if (mem_i.io)
            begin
               mem_rdata_o[k*8 +: 8] <= 8'h30 + 8'(io_rd);
               io_rd++;
            end
            else
               mem_rdata_o[k*8 +: 8] <= (mem_i.addr[7:0] + 8'(k)) ^ 8'h5A;
         end
      end
   end
   // Request held low until acknowledged
   always @(posedge clk_i)
      interrupt_control_unit_n_o <= rst_i ? 8'hFF : (interrupt_control_unit_n_o & ~raise_i) | ~ack_n_i;
endmodule
